// >>> rtl/eeprom_pkg.sv
// Shared constants and carrier types for the serial two-wire EEPROM core.
// Assumes a single 40 MHz system clock domain.
package eeprom_pkg;
	localparam int ADDR_W = 13;
	localparam int IDP_W = 5;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam logic [3:0] TYPE_MEM = 4'ha;
	localparam logic [3:0] TYPE_IDP = 4'hb;
	localparam int LOCK_ADDR_BIT = 10;
	localparam int LOCK_DATA_BIT = 1;
	localparam int CHK_W = 7;
	localparam int CLK_MHZ = 40;
	localparam int WRITE_TIME_US = 4;
	localparam int WRITE_CYC = WRITE_TIME_US * CLK_MHZ;
	// Code word: 32 data bits plus 7 Hamming check bits
	typedef struct packed {
		logic [CHK_W-1:0] chk;
		logic [31:0] data;
	} cword_t;
endpackage : eeprom_pkg

// >>> rtl/eeprom_core.sv
// Two-wire EEPROM slave: read acknowledge, power-on state, ECC groups.
// Assumes SCL/SDA from an external master; the pad resolves SDA from SDA_OE.
//
// Notes on behaviour
// - After each read byte, sample master acknowledge in the ninth slot.
// - No acknowledge in ninth slot stops output and returns to standby.
// - Acknowledged reads keep streaming; address counter wraps to zero.
// - Below the reset threshold every bus instruction is ignored.
// - After power-on reset the device is deselected and in standby.
// - Deselect after the stop ending a read and after a write cycle.
// - Each aligned four-byte group is one protected code word.
// - Single bit errors in a group are corrected invisibly on read.
// - A byte write rewrites check bits and the other three bytes.
// - Programming starts on any decoded byte or page write, and on ID-page or lock writes only while the ID page is unlocked.
// - Delivered main array reads as all ones.
// - Delivered ID page holds a three-byte identification code first.
`timescale 1ns/1ps
module eeprom_core
	import eeprom_pkg::*;
#(
	parameter int WRITE_CYCLES = WRITE_CYC,
	parameter logic [23:0] ID_CODE = 24'h123456, // Arbitrary value
	parameter logic [2:0] CHIP_ADDR = 3'h0
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic SYS_RST,
	// Supply above the reset threshold
	input wire logic VCC_OK,
	// Two-wire bus
	input wire logic SCL,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	// Status
	output logic SELECTED,
	output logic WRITE_BUSY
);
	localparam int NGRP = 1 << (ADDR_W - 2);
	typedef enum {ST_IDLE, ST_STA, ST_DEV, ST_DACK, ST_AH, ST_AHACK, ST_AL, ST_ALACK,
		ST_WDATA, ST_WACK, ST_RDATA, ST_RACK, ST_RNEXT, ST_PROG} st_t;

	cword_t mem [NGRP];
	logic [7:0] idp [1 << IDP_W];
	logic idp_lock_ff;

	// Hamming position of data bit i (skips powers of two)
	function automatic int dpos(input int i);
		int p;
		int k;
		p = 0;
		k = 0;
		for (int j = 1; j < 40; j++) begin
			if ((j & (j - 1)) != 0) begin
				if (k == i) p = j;
				k++;
			end
		end
		return p;
	endfunction : dpos

	function automatic logic [CHK_W-1:0] enc(input logic [31:0] d);
		logic [CHK_W-1:0] c;
		c = '0;
		for (int i = 0; i < 32; i++)
			for (int b = 0; b < 6; b++)
				if (((dpos(i) >> b) & 1) != 0) c[b] = c[b] ^ d[i];
		c[6] = ^{d, c[5:0]};
		return c;
	endfunction : enc

	// Corrects a single flipped data bit; check bit errors need no action
	function automatic logic [31:0] fix(input cword_t w);
		logic [CHK_W-1:0] s;
		logic [31:0] d;
		logic odd;
		s = enc(w.data) ^ w.chk;
		// Overall parity of the stored word flags a single error anywhere
		odd = ^w;
		d = w.data;
		for (int i = 0; i < 32; i++)
			if (s[5:0] == 6'(dpos(i)) && odd) d[i] = ~d[i];
		return d;
	endfunction : fix

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and bus condition detection
	logic [1:0] scl_s_ff, sda_s_ff;
	logic [1:0] vok_s_ff;
	logic scl_q_ff, sda_q_ff;
	always_ff @(posedge CLK) begin
		vok_s_ff <= {vok_s_ff[0], VCC_OK};
		scl_s_ff <= {scl_s_ff[0], SCL};
		sda_s_ff <= {sda_s_ff[0], SDA_IN};
		scl_q_ff <= scl_s_ff[1];
		sda_q_ff <= sda_s_ff[1];
	end
	// Supply monitor is asynchronous to CLK as well
	wire vok = vok_s_ff[1];
	wire scl = scl_s_ff[1];
	wire sda = sda_s_ff[1];
	wire scl_rise = scl & ~scl_q_ff;
	wire scl_fall = ~scl & scl_q_ff;
	wire start_c = scl & scl_q_ff & sda_q_ff & ~sda;
	wire stop_c = scl & scl_q_ff & ~sda_q_ff & sda;

	////////////////////////////////////////////////////////////////////////
	// Protocol state
	st_t st_ff, nxt_st;
	logic [2:0] bit_ff, nxt_bit;
	logic [7:0] sh_ff, nxt_sh;
	logic [ADDR_W-1:0] ptr_ff, nxt_ptr;
	logic [7:0] ah_ff, nxt_ah;
	logic idsel_ff, nxt_idsel;
	logic rw_ff, nxt_rw;
	logic oe_ff, nxt_oe;
	logic wpend_ff, nxt_wpend;
	logic [7:0] wbyte_ff, nxt_wbyte;
	logic [$clog2(WRITE_CYCLES+1)-1:0] tw_ff, nxt_tw;
	logic prog_go;

	wire [ADDR_W-3:0] grp = ptr_ff[ADDR_W-1:2];
	wire [31:0] rd_word = fix(mem[grp]);
	wire [7:0] rd_byte = idsel_ff ? idp[ptr_ff[IDP_W-1:0]] : rd_word[8*ptr_ff[1:0] +: 8];
	wire is_lock = idsel_ff & ptr_ff[LOCK_ADDR_BIT];

	// Next-state logic for the byte engine
	always_comb begin
		nxt_st = st_ff;
		nxt_bit = bit_ff;
		nxt_sh = sh_ff;
		nxt_ptr = ptr_ff;
		nxt_ah = ah_ff;
		nxt_idsel = idsel_ff;
		nxt_rw = rw_ff;
		nxt_oe = oe_ff;
		nxt_wpend = wpend_ff;
		nxt_wbyte = wbyte_ff;
		nxt_tw = tw_ff;
		prog_go = 1'b0;
		if (!vok) begin
			nxt_st = ST_IDLE;
			nxt_oe = 1'b0;
			nxt_wpend = 1'b0;
		end else if (st_ff == ST_PROG) begin
			if (tw_ff == '0) nxt_st = ST_IDLE;
			else nxt_tw = tw_ff - 1'b1;
		end else if (start_c) begin
			// The SCL fall that completes the start must not count as a bit
			nxt_st = ST_STA;
			nxt_bit = '0;
			nxt_oe = 1'b0;
			nxt_wpend = 1'b0;
		end else if (stop_c) begin
			nxt_oe = 1'b0;
			nxt_st = ST_IDLE;
			if (wpend_ff) begin
				nxt_st = ST_PROG;
				nxt_tw = ($bits(tw_ff))'(WRITE_CYCLES - 1);
				prog_go = 1'b1;
				nxt_wpend = 1'b0;
			end
		end else if (scl_rise) begin
			unique case (st_ff)
				ST_DEV, ST_AH, ST_AL, ST_WDATA: begin
					nxt_sh = {sh_ff[6:0], sda};
					nxt_bit = bit_ff + 3'h1;
				end
				ST_RACK: begin
					if (sda) begin
						nxt_st = ST_IDLE;
					end else begin
						nxt_st = ST_RNEXT;
						nxt_ptr = ptr_ff + 1'b1;
					end
				end
				default: ;
			endcase
		end else if (scl_fall) begin
			unique case (st_ff)
				ST_STA: nxt_st = ST_DEV;
				ST_DEV: if (bit_ff == 3'h0) begin
					if (sh_ff[7:1] == {TYPE_MEM, CHIP_ADDR} ||
						sh_ff[7:1] == {TYPE_IDP, CHIP_ADDR}) begin
						nxt_st = ST_DACK;
						nxt_oe = 1'b1;
						nxt_rw = sh_ff[0];
						nxt_idsel = sh_ff[4];
					end else nxt_st = ST_IDLE;
				end
				ST_AH: if (bit_ff == 3'h0) begin
					nxt_st = ST_AHACK;
					nxt_ah = sh_ff;
					nxt_oe = 1'b1;
				end
				ST_AL: if (bit_ff == 3'h0) begin
					nxt_st = ST_ALACK;
					nxt_ptr = ADDR_W'({ah_ff, sh_ff});
					nxt_oe = 1'b1;
				end
				ST_WDATA: if (bit_ff == 3'h0) begin
					nxt_st = ST_WACK;
					nxt_oe = ~(idsel_ff & idp_lock_ff);
					nxt_wbyte = sh_ff;
					nxt_wpend = ~(idsel_ff & idp_lock_ff);
				end
				ST_RNEXT: begin
					// Next byte of the stream, from the advanced pointer
					nxt_st = ST_RDATA;
					nxt_oe = ~rd_byte[7];
					nxt_sh = rd_byte;
					nxt_bit = 3'h1;
				end
				ST_DACK: begin
					nxt_st = rw_ff ? ST_RDATA : ST_AH;
					nxt_oe = rw_ff ? ~rd_byte[7] : 1'b0;
					nxt_sh = rd_byte;
					nxt_bit = rw_ff ? 3'h1 : 3'h0;
				end
				ST_AHACK: begin
					nxt_st = ST_AL;
					nxt_oe = 1'b0;
				end
				ST_ALACK, ST_WACK: begin
					nxt_st = ST_WDATA;
					nxt_oe = 1'b0;
				end
				ST_RDATA: begin
					if (bit_ff == 3'h0) begin
						nxt_st = ST_RACK;
						nxt_oe = 1'b0;
					end else begin
						nxt_oe = ~sh_ff[3'h7 - bit_ff];
						nxt_bit = bit_ff + 3'h1;
					end
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			st_ff <= ST_IDLE;
			bit_ff <= '0;
			sh_ff <= '0;
			ptr_ff <= '0;
			ah_ff <= '0;
			idsel_ff <= 1'b0;
			rw_ff <= 1'b0;
			oe_ff <= 1'b0;
			wpend_ff <= 1'b0;
			wbyte_ff <= '0;
			tw_ff <= '0;
		end else begin
			st_ff <= nxt_st;
			bit_ff <= nxt_bit;
			sh_ff <= nxt_sh;
			ptr_ff <= nxt_ptr;
			ah_ff <= nxt_ah;
			idsel_ff <= nxt_idsel;
			rw_ff <= nxt_rw;
			oe_ff <= nxt_oe;
			wpend_ff <= nxt_wpend;
			wbyte_ff <= nxt_wbyte;
			tw_ff <= nxt_tw;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Array update; a byte write re-encodes the whole corrected group
	logic [31:0] new_word;
	always_comb begin
		new_word = rd_word;
		new_word[8*ptr_ff[1:0] +: 8] = wbyte_ff;
	end

	logic init_ff;
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			init_ff <= 1'b1;
			idp_lock_ff <= 1'b0;
		end else if (init_ff) begin
			// Delivered contents rewritten after every reset, memory held in the array itself
			for (int g = 0; g < NGRP; g++) mem[g] <= '{chk: enc({4{ERASED_BYTE}}), data: {4{ERASED_BYTE}}};
			for (int i = 0; i < (1 << IDP_W); i++) idp[i] <= ERASED_BYTE;
			idp[0] <= ID_CODE[23:16];
			idp[1] <= ID_CODE[15:8];
			idp[2] <= ID_CODE[7:0];
			init_ff <= 1'b0;
		end else if (prog_go) begin
			if (is_lock) idp_lock_ff <= wbyte_ff[LOCK_DATA_BIT] | idp_lock_ff;
			else if (idsel_ff) idp[ptr_ff[IDP_W-1:0]] <= wbyte_ff;
			else mem[grp] <= '{chk: enc(new_word), data: new_word};
		end
	end

	// Outputs: open drain, only low is driven
	assign SDA_OUT = 1'b0;
	assign SDA_OE = oe_ff;
	assign SELECTED = (st_ff != ST_IDLE) && (st_ff != ST_PROG);
	assign WRITE_BUSY = (st_ff == ST_PROG);

	////////////////////////////////////////////////////////////////////////
	// Checks
	property p_nack_stop;
		@(posedge CLK) disable iff (SYS_RST)
		(vok && st_ff == ST_RACK && scl_rise && sda && !start_c && !stop_c)
			|=> (st_ff == ST_IDLE) ##1 !SDA_OE;
	endproperty
	a_nack_stop: assert property (p_nack_stop) else $error("read not ended on nack");

	property p_ack_next;
		@(posedge CLK) disable iff (SYS_RST)
		(vok && st_ff == ST_RACK && scl_rise && !sda && !start_c && !stop_c)
			|=> st_ff == ST_RNEXT && ptr_ff == $past(ptr_ff) + 1'b1;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("read stream did not advance");

	property p_por;
		@(posedge CLK) disable iff (SYS_RST)
		!vok |=> st_ff == ST_IDLE && !SDA_OE;
	endproperty
	a_por: assert property (p_por) else $error("bus active below threshold");

	property p_reset_idle;
		@(posedge CLK) disable iff (SYS_RST)
		$fell(SYS_RST) |-> !SELECTED && !WRITE_BUSY && !SDA_OE;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");

	property p_prog_end;
		@(posedge CLK) disable iff (SYS_RST)
		(st_ff == ST_PROG && tw_ff == '0 && vok) |=> !SELECTED && !WRITE_BUSY;
	endproperty
	a_prog_end: assert property (p_prog_end) else $error("no deselect after write");

	property p_launch;
		@(posedge CLK) disable iff (SYS_RST)
		prog_go |=> WRITE_BUSY [*2];
	endproperty
	a_launch: assert property (p_launch) else $error("write cycle not launched");
endmodule : eeprom_core

// >>> tb/i2c_master_model.sv
// Two-wire bus master model: drives SCL and pulls SDA low.
// Assumes a bench pull-up resolves SDA from every party.
`timescale 1ns/1ps
module i2c_master_model (
	// Clock
	input wire logic clk,
	// Bus
	output logic scl,
	output logic sda_low,
	input wire logic sda
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	// One 200 ns bit slot; SCL stands still between frames
	task automatic slot(input logic b, output logic r);
		repeat (2) @(posedge clk);
		sda_low <= ~b;
		repeat (2) @(posedge clk);
		scl <= 1'b1;
		repeat (3) @(posedge clk);
		r = sda;
		@(posedge clk);
		scl <= 1'b0;
	endtask : slot
	// Start, also usable as a repeated start: SDA falls while SCL is high
	task automatic start();
		repeat (2) @(posedge clk);
		sda_low <= 1'b0;
		repeat (2) @(posedge clk);
		scl <= 1'b1;
		repeat (4) @(posedge clk);
		sda_low <= 1'b1;
		repeat (4) @(posedge clk);
		scl <= 1'b0;
	endtask : start
	// Stop: SDA rises while SCL is high, then the bus stands idle
	task automatic stop();
		repeat (2) @(posedge clk);
		sda_low <= 1'b1;
		repeat (2) @(posedge clk);
		scl <= 1'b1;
		repeat (4) @(posedge clk);
		sda_low <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : stop
	// Byte out, MSB first; ack 0 means acknowledged
	task automatic put(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) slot(d[i], r);
		slot(1'b1, ack);
	endtask : put
	// Byte in; ack low keeps the stream going, high ends it
	task automatic get(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			slot(1'b1, r);
			d[i] = r;
		end
		slot(ack, r);
	endtask : get
endmodule : i2c_master_model

// >>> tb/test_i2c_eeprom_read_ack_por_ecc.sv
// Self-checking bench for the EEPROM core.
// Assumes the master model above; write cycle set to 200 clocks, longer than the 160-clock default.
`timescale 1ns/1ps
module test_i2c_eeprom_read_ack_por_ecc;
	import eeprom_pkg::*;
	typedef struct packed {
		logic [3:0] t;
		logic [12:0] a;
		logic [7:0] d;
		logic [1:0] n;
		logic rd;
	} row_t;
	localparam logic [23:0] ID = 24'h123456; // Arbitrary value
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic vcc_ok = 1'b1;
	logic scl, sda_low, sda_oe, sda_out, selected, write_busy;
	wire sda;
	int num_errors = 0;
	int tests_run = 0;
	// Byte write, page write, ID-page write, lock
	row_t rows [4] = '{'{TYPE_MEM, 13'h0005, 8'h3c, 2'd1, 1'b1},
		'{TYPE_MEM, 13'h0041, 8'ha5, 2'd2, 1'b0}, '{TYPE_IDP, 13'h0005, 8'h77, 2'd1, 1'b1},
		'{TYPE_IDP, 13'h0400, 8'h02, 2'd1, 1'b0}};
	// Pull-up: line is high unless someone pulls it
	assign sda = ~(sda_low | sda_oe);
	always #12.5 clk = ~clk;
	i2c_master_model i_master (.clk(clk), .scl(scl), .sda_low(sda_low), .sda(sda));
	eeprom_core #(.WRITE_CYCLES(200), .ID_CODE(ID)) i_eeprom_core (.CLK(clk),
		.SYS_RST(sys_rst), .VCC_OK(vcc_ok), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
		.SDA_OE(sda_oe), .SELECTED(selected), .WRITE_BUSY(write_busy));
	////////////////////////////////////////////////////////////////
	// Compare and tasks
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		tests_run++;
		if (s !== e) begin
			num_errors++;
			$display("BAD %0t: got %h want %h", $time, s, e);
		end
	endtask : chk
	task automatic end_of_test();
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : end_of_test
	task automatic sel(input logic [7:0] b, input logic e);
		logic k;
		i_master.put(b, k);
		chk({7'h0, k}, {7'h0, e});
	endtask : sel
	task automatic addr(input logic [3:0] t, input logic [12:0] a);
		i_master.start();
		sel({t, 3'h0, 1'b0}, 1'b0);
		sel({3'h0, a[12:8]}, 1'b0);
		sel(a[7:0], 1'b0);
	endtask : addr
	// Deselected shortly after the transfer ends
	task automatic idle();
		repeat (8) @(posedge clk);
		chk({7'h0, selected}, 8'h00);
	endtask : idle
	task automatic rd(input logic [3:0] t, input logic [12:0] a, input logic [7:0] e[$]);
		logic [7:0] d;
		addr(t, a);
		i_master.start();
		sel({t, 3'h0, 1'b1}, 1'b0);
		foreach (e[i]) begin
			i_master.get(i == e.size() - 1, d);
			chk(d, e[i]);
		end
		i_master.stop();
		idle();
	endtask : rd
	task automatic wr(input row_t r);
		addr(r.t, r.a);
		for (int i = 0; i < r.n; i++) sel(r.d, 1'b0);
		i_master.stop();
		for (int i = 0; i < 40 && write_busy !== 1'b1; i++) @(posedge clk);
		chk({7'h0, write_busy}, 8'h01);
		i_master.start();
		sel({r.t, 3'h0, 1'b0}, 1'b1);
		i_master.stop();
		for (int i = 0; i < 400 && write_busy !== 1'b0; i++) @(posedge clk);
		chk({7'h0, write_busy}, 8'h00);
		idle();
	endtask : wr
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (10) @(posedge clk);
		chk({4'h0, sda_out, sda_oe, selected, write_busy}, 8'h00);
		sys_rst <= 1'b0;
		repeat (8300) @(posedge clk);
		rd(TYPE_MEM, 13'h1ffe, '{ERASED_BYTE, ERASED_BYTE, ERASED_BYTE});
		rd(TYPE_IDP, 13'h0000, '{ID[23:16], ID[15:8], ID[7:0]});
		foreach (rows[i]) begin
			wr(rows[i]);
			if (rows[i].rd) rd(rows[i].t, rows[i].a, '{rows[i].d});
			if (i == 0) rd(TYPE_MEM, 13'h0004, '{ERASED_BYTE, 8'h3c, ERASED_BYTE});
		end
		// Locked ID page: data byte must go unanswered
		addr(TYPE_IDP, 13'h0005);
		sel(8'h00, 1'b1);
		i_master.stop();
		idle();
		// Supply below threshold: the select code must go unanswered
		vcc_ok <= 1'b0;
		i_master.start();
		sel({TYPE_MEM, 3'h0, 1'b0}, 1'b1);
		i_master.stop();
		vcc_ok <= 1'b1;
		idle();
		// Reset in mid-run, then the bus must answer again
		sys_rst <= 1'b1;
		repeat (10) @(posedge clk);
		chk({4'h0, sda_out, sda_oe, selected, write_busy}, 8'h00);
		sys_rst <= 1'b0;
		repeat (20) @(posedge clk);
		rd(TYPE_MEM, 13'h1ffe, '{ERASED_BYTE, ERASED_BYTE});
		end_of_test();
	end
	// Watchdog
	initial begin
		repeat (60000) @(posedge clk);
		num_errors++;
		end_of_test();
	end
endmodule : test_i2c_eeprom_read_ack_por_ecc
